// ===== fcf_map.vh
// Behaviour
// R1: two 12-bit offsets, empty and full, loaded from low data bits, readable.
// R2: offset-load and write enable low: writes cycle empty, full, empty offset.
// R3: write sequence pointer persists after offset-load returns high.
// R4: offset-load low with write enable high: write edges do nothing.
// R5: offset-load and read enable low: reads cycle offsets with own pointer.
// R6: controller never reads and writes the offsets at the same time.
// R7: controller drives zero on offset bits it does not program.
// R8: first-in-chain low on single or first device, high on others.
// R9: chain inputs grounded when single, else tied to previous chain outputs.
// R10: full flag low at full depth, blocking further writes.
// R11: full flag updates on write clock edges only.
// R12: empty flag low when no words remain, updates on read edges.
// R13: almost-full low from depth minus full offset through full.
// R14: default full offset 31, 63 or 127 by depth.
// R15: almost-full driven low on write edges, high on read edges.
// R16: almost-empty low at empty offset words or fewer, high above.
// R17: default empty offset 31, 63 or 127 by depth.
// R18: almost-empty driven low on read edges, high on write edges.
// R19: with both chain inputs grounded, write chain out is half-full.
// R20: half-full low above half depth, high again at half or less.
// R21: in expansion, write chain out pulses on last location write.
// R22: in expansion, read chain out pulses on last location read.
// R23: reset clears pointers, output register, restores default offsets.
// R24: reset drives full, half-full, almost-full high; empty, almost-empty low.
// R25: write ignored while full, read ignored while empty.
`ifndef FCF_MAP_VH
`define FCF_MAP_VH
// ****************************************
// widths and depths
// ****************************************
`define FCF_DATA_W   18
`define FCF_OFF_W    12
`define FCF_DEPTH    256
`define FCF_AW       8
`define FCF_BUF_N    2
// ****************************************
// default offsets by depth
// ****************************************
`define FCF_DEPTH_S  256
`define FCF_DEPTH_M  512
`define FCF_DFLT_S   12'h01f
`define FCF_DFLT_M   12'h03f
`define FCF_DFLT_L   12'h07f
// ****************************************
// sequence selects and reset values
// ****************************************
`define FCF_SEL_EMPTY 1'b0
`define FCF_RST_HI    1'b1
`define FCF_RST_LO    1'b0
`endif

// ===== fcf_ctrl.v
`timescale 1ns/10ps
`include "fcf_map.vh"

module fcf_ctrl
#(
  parameter DEPTH = `FCF_DEPTH,
  parameter AW    = `FCF_AW
)
(
  input  wire                    clk,
  input  wire                    nrst,
  input  wire [`FCF_DATA_W-1:0]  data_in,
  input  wire                    write_en_n,
  input  wire                    read_en_n,
  input  wire                    offset_load_n,
  input  wire                    first_in_chain_n,
  input  wire                    write_chain_in_n,
  input  wire                    read_chain_in_n,
  input  wire                    out_ready,
  output reg  [`FCF_DATA_W-1:0]  data_out,
  output reg                     out_valid,
  output reg                     read_room,
  output reg                     full_flag_n,
  output reg                     empty_flag_n,
  output reg                     almost_full_n,
  output reg                     almost_empty_n,
  output reg                     write_chain_out_n,
  output reg                     read_chain_out_n
);

  // ****************************************
  // functions
  // ****************************************

  // default threshold for a given depth
  function [`FCF_OFF_W-1:0] dflt_off;
    input integer d;
    begin
      if (d == `FCF_DEPTH_S)
        dflt_off = `FCF_DFLT_S;
      else if (d == `FCF_DEPTH_M)
        dflt_off = `FCF_DFLT_M;
      else
        dflt_off = `FCF_DFLT_L;
    end
  endfunction

  // zero-extend a word count to 16 bits
  function [15:0] wide;
    input [AW:0] c;
    begin
      wide = {{(15-AW){1'b0}}, c};
    end
  endfunction

  // 32-bit copies, then cut to the width each compare needs
  localparam [31:0]   DEPTH_32 = DEPTH;
  localparam [31:0]   HALF_32  = DEPTH / 2;
  localparam [31:0]   LAST_32  = DEPTH - 1;
  localparam [15:0]   DEPTH_W  = DEPTH_32[15:0];
  localparam [15:0]   HALF_W   = HALF_32[15:0];
  localparam [AW-1:0] LAST     = LAST_32[AW-1:0];
  localparam [AW:0]   FULL_C   = DEPTH_32[AW:0];

  // ****************************************
  // state
  // ****************************************
  reg [`FCF_DATA_W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]          wptr_reg;
  reg [AW-1:0]          rptr_reg;
  reg [AW:0]            cnt_reg;
  reg [`FCF_OFF_W-1:0]  empty_threshold_offset_reg;
  reg [`FCF_OFF_W-1:0]  full_threshold_offset_reg;
  reg                   wsel_reg;
  reg                   rsel_reg;
  reg                   init_reg;
  reg                   wtok_reg;
  reg                   rtok_reg;
  reg [`FCF_DATA_W-1:0] buf1_reg;
  reg [1:0]             bcnt_reg;

  wire [`FCF_OFF_W-1:0] offset_data_in;
  wire                  single;
  wire                  full;
  wire                  empty;
  wire                  buf_room;
  wire                  do_write;
  wire                  do_read;
  wire                  do_owr;
  wire                  do_ord;
  wire                  push;
  wire                  pop;
  wire [`FCF_DATA_W-1:0] push_data;
  wire [`FCF_OFF_W-1:0] rd_off;
  reg  [AW:0]           cnt_next;
  reg  [1:0]            bcnt_next;

  assign offset_data_in = data_in[`FCF_OFF_W-1:0];

  // both chain inputs grounded selects single mode
  assign single = ~write_chain_in_n & ~read_chain_in_n; // R19

  assign full     = (cnt_reg == FULL_C);
  assign empty    = (cnt_reg == {(AW+1){1'b0}});
  assign buf_room = (bcnt_reg != 2'h2);

  // normal accesses gated by flags and chain ownership
  assign do_write = offset_load_n & ~write_en_n & ~full
                    & (single | wtok_reg); // R25
  assign do_read  = offset_load_n & ~read_en_n & ~empty & buf_room
                    & (single | rtok_reg); // R25

  // offset accesses; write enable high leaves the pointer alone
  assign do_owr = ~offset_load_n & ~write_en_n; // R2 R4
  assign do_ord = ~offset_load_n & ~read_en_n & buf_room; // R5

  // offset readback uses its own pointer
  assign rd_off = (rsel_reg == `FCF_SEL_EMPTY) ?
                  empty_threshold_offset_reg : full_threshold_offset_reg; // R5

  assign push      = do_read | do_ord;
  assign push_data = do_ord ? {{(`FCF_DATA_W-`FCF_OFF_W){1'b0}}, rd_off}
                            : mem[rptr_reg];
  assign pop       = out_valid & out_ready;

  // ****************************************
  // occupancy
  // ****************************************

  // next word count
  always @*
  begin
    cnt_next = cnt_reg;
    if (do_write & ~do_read)
      cnt_next = cnt_reg + 1'b1;
    else if (do_read & ~do_write)
      cnt_next = cnt_reg - 1'b1;
  end

  // next buffer fill
  always @*
  begin
    bcnt_next = bcnt_reg;
    if (push & ~pop)
      bcnt_next = bcnt_reg + 1'b1;
    else if (pop & ~push)
      bcnt_next = bcnt_reg - 1'b1;
  end

  // ****************************************
  // storage array
  // ****************************************

  // data words, no reset needed
  always @(posedge clk)
  begin
    if (do_write)
      mem[wptr_reg] <= data_in;
  end

  // ****************************************
  // pointers, count and offsets
  // ****************************************

  // pointer and offset registers
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wptr_reg                   <= {AW{1'b0}}; // R23
      rptr_reg                   <= {AW{1'b0}}; // R23
      cnt_reg                    <= {(AW+1){1'b0}};
      empty_threshold_offset_reg <= dflt_off(DEPTH); // R17 R23
      full_threshold_offset_reg  <= dflt_off(DEPTH); // R14 R23
      wsel_reg                   <= `FCF_SEL_EMPTY;
      rsel_reg                   <= `FCF_SEL_EMPTY;
    end
    else
    begin
      cnt_reg <= cnt_next;
      if (do_write)
        wptr_reg <= wptr_reg + 1'b1;
      if (do_read)
        rptr_reg <= rptr_reg + 1'b1;
      // offset write sequence, held while load is high
      if (do_owr)
      begin
        if (wsel_reg == `FCF_SEL_EMPTY)
          empty_threshold_offset_reg <= offset_data_in; // R1 R2
        else
          full_threshold_offset_reg <= offset_data_in; // R1 R2
        wsel_reg <= ~wsel_reg; // R2 R3
      end
      if (do_ord)
        rsel_reg <= ~rsel_reg; // R5
    end
  end

  // ****************************************
  // chain ownership
  // ****************************************

  // strap is caught on the first edge after reset
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      init_reg <= 1'b1;
      wtok_reg <= 1'b0;
      rtok_reg <= 1'b0;
    end
    else if (init_reg)
    begin
      init_reg <= 1'b0;
      wtok_reg <= ~first_in_chain_n; // R8
      rtok_reg <= ~first_in_chain_n; // R8
    end
    else
    begin
      // token handed on after last location, taken on pulse in
      if (do_write & (wptr_reg == LAST))
        wtok_reg <= 1'b0; // R21
      else if (~write_chain_in_n & ~single)
        wtok_reg <= 1'b1; // R9
      if (do_read & (rptr_reg == LAST))
        rtok_reg <= 1'b0; // R22
      else if (~read_chain_in_n & ~single)
        rtok_reg <= 1'b1; // R9
    end
  end

  // ****************************************
  // status flags
  // ****************************************

  // flags follow the count after each access
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      full_flag_n       <= `FCF_RST_HI; // R24
      empty_flag_n      <= `FCF_RST_LO; // R24
      almost_full_n     <= `FCF_RST_HI; // R24
      almost_empty_n    <= `FCF_RST_LO; // R24
      write_chain_out_n <= `FCF_RST_HI; // R24
      read_chain_out_n  <= `FCF_RST_HI;
    end
    else
    begin
      full_flag_n  <= ~(cnt_next == FULL_C); // R10 R11
      empty_flag_n <= ~(cnt_next == {(AW+1){1'b0}}); // R12
      // low from depth minus offset through full
      almost_full_n <= ~(wide(cnt_next) + {4'h0, full_threshold_offset_reg}
                         >= DEPTH_W); // R13 R15
      // low at offset or fewer words
      almost_empty_n <= ~(wide(cnt_next)
                          <= {4'h0, empty_threshold_offset_reg}); // R16 R18
      // half-full in single mode, else last-location pulse
      if (single)
        write_chain_out_n <= ~(wide(cnt_next) > HALF_W); // R19 R20
      else
        write_chain_out_n <= ~(do_write & (wptr_reg == LAST)); // R21
      read_chain_out_n <= ~(~single & do_read & (rptr_reg == LAST)); // R22
    end
  end

  // ****************************************
  // two-entry output buffer
  // ****************************************

  // head entry drives data_out directly
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_out  <= {`FCF_DATA_W{1'b0}}; // R23
      buf1_reg  <= {`FCF_DATA_W{1'b0}};
      bcnt_reg  <= 2'h0;
      out_valid <= 1'b0;
      read_room <= 1'b1;
    end
    else
    begin
      bcnt_reg  <= bcnt_next;
      out_valid <= (bcnt_next != 2'h0);
      read_room <= (bcnt_next != 2'h2);
      if (pop)
      begin
        if (bcnt_reg == 2'h2)
        begin
          data_out <= buf1_reg;
          if (push)
            buf1_reg <= push_data;
        end
        else if (push)
          data_out <= push_data;
      end
      else if (push)
      begin
        if (bcnt_reg == 2'h0)
          data_out <= push_data;
        else
          buf1_reg <= push_data;
      end
    end
  end

endmodule

// ===== fcf_ctrl_properties.sv
`timescale 1ns/10ps
// ****************************
// fifo control port checks
// ****************************
module fcf_ctrl_properties
(
  input wire        clk,
  input wire        nrst,
  input wire [17:0] data_in,
  input wire        write_en_n,
  input wire        read_en_n,
  input wire        offset_load_n,
  input wire        first_in_chain_n,
  input wire        write_chain_in_n,
  input wire        read_chain_in_n,
  input wire        out_ready,
  input wire [17:0] data_out,
  input wire        out_valid,
  input wire        read_room,
  input wire        full_flag_n,
  input wire        empty_flag_n,
  input wire        almost_full_n,
  input wire        almost_empty_n,
  input wire        write_chain_out_n,
  input wire        read_chain_out_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // both chain inputs low means single mode
  wire single = !write_chain_in_n && !read_chain_in_n;
  property p_full_hold; !full_flag_n && read_en_n |=> !full_flag_n; endproperty
  a_full_hold: assert property (p_full_hold) else $error("full left without read");
  property p_full_fell; $fell(full_flag_n) |-> $past(!write_en_n && offset_load_n); endproperty
  a_full_fell: assert property (p_full_fell) else $error("full without write");
  property p_empty_hold; !empty_flag_n && write_en_n |=> !empty_flag_n; endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("empty left without write");
  property p_af_full; !full_flag_n |-> !almost_full_n; endproperty
  a_af_full: assert property (p_af_full) else $error("almost full high when full");
  property p_ae_empty; !empty_flag_n |-> !almost_empty_n; endproperty
  a_ae_empty: assert property (p_ae_empty) else $error("almost empty high when empty");
  property p_hf_full; single && !full_flag_n |-> !write_chain_out_n; endproperty
  a_hf_full: assert property (p_hf_full) else $error("half full high when full");
  property p_hf_empty; single && !empty_flag_n |-> write_chain_out_n; endproperty
  a_hf_empty: assert property (p_hf_empty) else $error("half full low when empty");
  property p_out_hold; out_valid && !out_ready |=> out_valid && $stable(data_out); endproperty
  a_out_hold: assert property (p_out_hold) else $error("stalled word lost");
  property p_wxo_pulse; !single && !write_chain_out_n |=> write_chain_out_n; endproperty
  a_wxo_pulse: assert property (p_wxo_pulse) else $error("write pulse too long");
  property p_rxo_single; single |-> read_chain_out_n; endproperty
  a_rxo_single: assert property (p_rxo_single) else $error("read pulse in single mode");
endmodule

bind fcf_ctrl fcf_ctrl_properties fcf_ctrl_properties_inst
(
  .clk               (clk),
  .nrst              (nrst),
  .data_in           (data_in),
  .write_en_n        (write_en_n),
  .read_en_n         (read_en_n),
  .offset_load_n     (offset_load_n),
  .first_in_chain_n  (first_in_chain_n),
  .write_chain_in_n  (write_chain_in_n),
  .read_chain_in_n   (read_chain_in_n),
  .out_ready         (out_ready),
  .data_out          (data_out),
  .out_valid         (out_valid),
  .read_room         (read_room),
  .full_flag_n       (full_flag_n),
  .empty_flag_n      (empty_flag_n),
  .almost_full_n     (almost_full_n),
  .almost_empty_n    (almost_empty_n),
  .write_chain_out_n (write_chain_out_n),
  .read_chain_out_n  (read_chain_out_n)
);

// ===== fcf_sink.sv
`timescale 1ns/10ps
module fcf_sink
(
  input wire clk,
  input wire nrst,
  input wire slow,
  output reg out_ready
);
  reg [1:0] phase_reg;
  // ready every cycle, or one cycle in four when slow
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      phase_reg <= 2'h0;
    else
      phase_reg <= phase_reg + 2'h1;
    out_ready <= nrst && (!slow || phase_reg == 2'h3);
  end
endmodule

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
  reg         clk;
  reg         nrst;
  reg  [17:0] data_in;
  reg         write_en_n;
  reg         read_en_n;
  reg         offset_load_n;
  reg         slow;
  reg         first_in_chain_n;
  reg         write_chain_in_n;
  reg         read_chain_in_n;
  wire        read_room;
  integer     rxo_lows;
  integer     room_lows;
  wire        out_ready;
  wire [17:0] data_out;
  wire        out_valid;
  wire [5:0]  flags;
  integer     num_errors;
  integer     cmp_count;
  integer     i;
  integer     k;
  reg  [10:0] rows [0:8];
  reg  [17:0] exp_q [$];

  fcf_ctrl #(.DEPTH(16), .AW(4)) fcf_ctrl_inst
  (
    .clk               (clk),
    .nrst              (nrst),
    .data_in           (data_in),
    .write_en_n        (write_en_n),
    .read_en_n         (read_en_n),
    .offset_load_n     (offset_load_n),
    .first_in_chain_n  (first_in_chain_n),
    .write_chain_in_n  (write_chain_in_n),
    .read_chain_in_n   (read_chain_in_n),
    .out_ready         (out_ready),
    .data_out          (data_out),
    .out_valid         (out_valid),
    .read_room         (read_room),
    .full_flag_n       (flags[4]),
    .empty_flag_n      (flags[0]),
    .almost_full_n     (flags[3]),
    .almost_empty_n    (flags[1]),
    .write_chain_out_n (flags[2]),
    .read_chain_out_n  (flags[5])
  );
  fcf_sink fcf_sink_inst (.clk(clk), .nrst(nrst), .slow(slow), .out_ready(out_ready));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input [17:0] e, input [17:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task close_out;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task wr(input ld_n, input [17:0] d);
    @(posedge clk);
    offset_load_n <= ld_n;
    write_en_n <= 1'b0;
    data_in <= d;
    @(posedge clk);
    offset_load_n <= 1'b1;
    write_en_n <= 1'b1;
  endtask

  // read until every expected word arrived, bounded
  task drain;
    integer n;
    @(posedge clk);
    read_en_n <= 1'b0;
    for (n = 0; n < 400 && exp_q.size() > 0; n = n + 1)
      @(posedge clk);
    repeat (4) @(posedge clk);
    read_en_n <= 1'b1;
    if (exp_q.size() > 0)
    begin
      num_errors = num_errors + 1;
      close_out;
    end
  endtask

  task rdoff(input [11:0] e, input [11:0] f);
    exp_q.push_back({6'h00, e});
    exp_q.push_back({6'h00, f});
    @(posedge clk);
    offset_load_n <= 1'b0;
    read_en_n <= 1'b0;
    repeat (2) @(posedge clk);
    offset_load_n <= 1'b1;
    read_en_n <= 1'b1;
    drain;
  endtask

  // every accepted word in order, none past the last; pulse and stall cycles counted
  always @(posedge clk)
  begin
    if (nrst && out_valid && out_ready)
      chk("word", exp_q.size() > 0 ? exp_q.pop_front() : 18'h3ffff, data_out);
    if (nrst && !flags[5])
      rxo_lows = rxo_lows + 1;
    if (nrst && !read_room)
      room_lows = room_lows + 1;
  end

  initial
  begin
    num_errors = 0;
    cmp_count = 0;
    k = 0;
    nrst = 1'b0;
    data_in = 18'h00000;
    write_en_n = 1'b1;
    read_en_n = 1'b1;
    offset_load_n = 1'b1;
    slow = 1'b0;
    first_in_chain_n = 1'b0;
    write_chain_in_n = 1'b0;
    read_chain_in_n = 1'b0;
    rxo_lows = 0;
    room_lows = 0;
    // word count in the upper bits, flag set below
    rows = '{11'h03c, 11'h0fd, 11'h13f, 11'h23f, 11'h27b, 11'h2fb, 11'h333, 11'h3f3, 11'h423};
    repeat (16) @(posedge clk);
    chk("rst_flags", 18'h0003c, {12'h000, flags});
    chk("rst_data", 18'h00000, data_out);
    nrst <= 1'b1;
    rdoff(12'h07f, 12'h07f);
    wr(1'b0, 18'h00003);
    @(posedge clk);
    offset_load_n <= 1'b0;
    data_in <= 18'h00009;
    @(posedge clk);
    offset_load_n <= 1'b1;
    wr(1'b0, 18'h00004);
    rdoff(12'h003, 12'h004);
    for (i = 0; i < 9; i = i + 1)
    begin
      while (k < rows[i][10:6])
      begin
        exp_q.push_back(18'h00100 + k[17:0]);
        wr(1'b1, 18'h00100 + k[17:0]);
        k = k + 1;
      end
      #1;
      chk("flags", {12'h000, rows[i][5:0]}, {12'h000, flags});
    end
    wr(1'b1, 18'h3ffff);
    #1;
    chk("full_flags", 18'h00023, {12'h000, flags});
    slow <= 1'b1;
    drain;
    #1;
    chk("empty_flags", 18'h0003c, {12'h000, flags});
    wr(1'b1, 18'h00055);
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    #1;
    chk("rst2_flags", 18'h0003c, {12'h000, flags});
    chk("rst2_data", 18'h00000, data_out);
    @(posedge clk);
    nrst <= 1'b1;
    rdoff(12'h07f, 12'h07f);
    // expansion mode, not first in chain: no ownership until handed on
    @(posedge clk);
    nrst <= 1'b0;
    first_in_chain_n <= 1'b1;
    write_chain_in_n <= 1'b1;
    read_chain_in_n <= 1'b1;
    @(posedge clk);
    nrst <= 1'b1;
    wr(1'b1, 18'h00077);
    #1;
    chk("no_wtok", 18'h00000, {17'h00000, flags[0]});
    // hand over write then read ownership, one pulse each
    @(posedge clk);
    write_chain_in_n <= 1'b0;
    @(posedge clk);
    write_chain_in_n <= 1'b1;
    read_chain_in_n <= 1'b0;
    @(posedge clk);
    read_chain_in_n <= 1'b1;
    for (i = 0; i < 16; i = i + 1)
    begin
      exp_q.push_back(18'h00200 + i[17:0]);
      wr(1'b1, 18'h00200 + i[17:0]);
    end
    #1;
    chk("wxo_pulse", 18'h00000, {17'h00000, flags[2]});
    @(posedge clk);
    #1;
    chk("wxo_end", 18'h00001, {17'h00000, flags[2]});
    drain;
    chk("rxo_pulses", 18'h00001, rxo_lows[17:0]);
    chk("room_low", 18'h00001, {17'h00000, room_lows > 0});
    wr(1'b1, 18'h00078);
    #1;
    chk("wtok_gone", 18'h00000, {17'h00000, flags[0]});
    close_out;
  end
endmodule
